// [verilog/axis_unit_defs.vh]
// Constants for the axis unit bus decode and status indication block.
// How it works
// - Module number N selects window 0xFF-N.
// - Window lies in passive-subscriber segment.
// - Switch value is plain binary module number.
// - Up to 256 cards, distinct numbers only.
// - Ready indicator mirrors axis-ready output.
// - Limit indicator lit at limit position.
// - Separate positive and negative direction indicators.
// - In-position indicator lit inside target window.
// - Reference indicator lit at reference point.
// - Front reset resets only this card.
// - Card is target only, never initiates.
`ifndef AXIS_UNIT_DEFS_VH
`define AXIS_UNIT_DEFS_VH
`define PASSIVE_SEGMENT   16'h2000
`define WINDOW_TOP_PAGE   8'hFF
`define REG_CONTROL       8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STATUS    8'h08
`define REG_IRQ_MASK      8'h0C
`define REG_MODULE_NUMBER 8'h10
`define REG_WINDOW_BASE   8'h14
`define REG_HITS          8'h18
`define CTRL_READY_BIT    0
`define CTRL_RESET_VALUE  8'h00
`define EV_READY_BIT      0
`define EV_LIMIT_BIT      1
`define EV_REF_BIT        2
`define EV_TARGET_BIT     3
`define EV_HIT_BIT        4
`define EV_WIDTH          5
`define RESET_PULSE_NS    100
`define RESET_PULSE_CYC   ((`RESET_PULSE_NS + 4) / 5)
`define UNMAPPED_DATA     32'hDEADBEEF
`endif

// [verilog/window_decoder.v]
// Address window decoder for the backplane bus subscriber.
`default_nettype none
module window_decoder (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // Module number switch, already synchronised
   input  wire [7:0]  moduleNumber,
   // Bus address
   input  wire [15:0] busSegment,
   input  wire [15:0] busOffset,
   // Decode results
   output reg         windowHit,
   output reg  [15:0] windowBase
);
`include "axis_unit_defs.vh"
   wire [7:0] pageSel;
   assign pageSel = `WINDOW_TOP_PAGE - moduleNumber;
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         windowHit  <= 1'b0;
         windowBase <= 16'h0000;
      end else begin
         windowBase <= {pageSel, 8'h00};
         windowHit  <= (busSegment == `PASSIVE_SEGMENT) && (busOffset[15:8] == pageSel);
      end
   end
endmodule
`default_nettype wire

// [verilog/axis_unit_bus_decode_status.v]
// Backplane slave decode, front-panel status indicators and register file.
//
// Implementation choices: register access over Avalon-MM and the address map.
`default_nettype none
module axis_unit_bus_decode_status (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        frontResetBtn_n,
   // Module number switch
   input  wire [7:0]  module_number_switch,
   // Backplane bus, target only
   input  wire [15:0] sysBusSegment,
   input  wire [15:0] sysBusOffset,
   input  wire        sysBusRead,
   input  wire        sysBusWrite,
   input  wire [15:0] sysBusWrData,
   output reg  [15:0] sysBusRdData,
   output reg         sysBusRdDataOe,
   output wire        sysBusReady,
   output wire        sysBusReadyOe,
   // Axis state from positioning core
   input  wire        axisLimitReached,
   input  wire        driveMovingPos,
   input  wire        driveMovingNeg,
   input  wire        axisInTarget,
   input  wire        refPointReached,
   input  wire [15:0] axisStatusWord,
   // Front panel indicators, axis-ready output and card reset
   output reg         axisReadyOut,
   output reg         readyIndicator,
   output reg         limitIndicator,
   output reg         dirPosIndicator,
   output reg         dirNegIndicator,
   output reg         targetIndicator,
   output reg         reference_reached_indicator,
   output reg         cardReset,
   // Avalon-MM register slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // Interrupt
   output wire        irq
);
`include "axis_unit_defs.vh"
   localparam ST_IDLE = 3'b001;
   localparam ST_DONE = 3'b010;
   localparam ST_HOLD = 3'b100;
   localparam [31:0] RST_LOAD = `RESET_PULSE_CYC;

   // Two-flop synchronisers for pins.
   reg [7:0] swMeta_q;
   reg [7:0] swSync_q;
   reg [5:0] pinMeta_q;
   reg [5:0] pinSync_q;
   reg       btnMeta_q;
   reg       btnSync_q;
   reg       btnPrev_q;
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         swMeta_q  <= 8'h00;
         swSync_q  <= 8'h00;
         pinMeta_q <= 6'h00;
         pinSync_q <= 6'h00;
         btnMeta_q <= 1'b1;
         btnSync_q <= 1'b1;
         btnPrev_q <= 1'b1;
      end else begin
         swMeta_q  <= module_number_switch;
         swSync_q  <= swMeta_q;
         pinMeta_q <= {axisLimitReached, driveMovingPos, driveMovingNeg,
                       axisInTarget, refPointReached, 1'b0};
         pinSync_q <= pinMeta_q;
         btnMeta_q <= frontResetBtn_n;
         btnSync_q <= btnMeta_q;
         btnPrev_q <= btnSync_q;
      end
   end

   // Card-local reset pulse from the front button.
   reg [7:0] rstCnt_q;
   wire      btnPress = btnPrev_q & ~btnSync_q;
   wire      localRst = (rstCnt_q != 8'h00);
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         rstCnt_q  <= 8'h00;
         cardReset <= 1'b0;
      end else begin
         if (btnPress)
            rstCnt_q <= RST_LOAD[7:0];
         else if (localRst)
            rstCnt_q <= rstCnt_q - 8'h01;
         cardReset <= btnPress | (rstCnt_q > 8'h01);
      end
   end
   wire cardRst_n = rst_n & ~localRst;

   // Window decode.
   wire        windowHit;
   wire [15:0] windowBase;
   window_decoder u_decoder (
      .ref_clk      (ref_clk),
      .rst_n        (cardRst_n),
      .moduleNumber (swSync_q),
      .busSegment   (sysBusSegment),
      .busOffset    (sysBusOffset),
      .windowHit    (windowHit),
      .windowBase   (windowBase)
   );

   // Control register and status indicators.
   reg [7:0] ctrl_q;
   always @(posedge ref_clk) begin
      if (!cardRst_n) begin
         axisReadyOut                <= 1'b0;
         readyIndicator              <= 1'b0;
         limitIndicator              <= 1'b0;
         dirPosIndicator             <= 1'b0;
         dirNegIndicator             <= 1'b0;
         targetIndicator             <= 1'b0;
         reference_reached_indicator <= 1'b0;
      end else begin
         axisReadyOut                <= ctrl_q[`CTRL_READY_BIT];
         readyIndicator              <= ctrl_q[`CTRL_READY_BIT];
         limitIndicator              <= pinSync_q[5];
         dirPosIndicator             <= pinSync_q[4] & ~pinSync_q[3];
         dirNegIndicator             <= pinSync_q[3] & ~pinSync_q[4];
         targetIndicator             <= pinSync_q[2];
         reference_reached_indicator <= pinSync_q[1];
      end
   end

   // Backplane target cycle: answers only inside the window.
   reg [2:0]  busSt_q;
   reg [15:0] mailbox_q;
   reg [15:0] hits_q;
   reg        hitEv;
   reg        reqSeen_q;
   wire       busReq = sysBusRead | sysBusWrite;
   // The decode is registered, so a request is taken only once its own address has been
   // decoded; otherwise a stale hit from the previous address could answer a foreign cycle.
   always @(posedge ref_clk) begin
      if (!cardRst_n) begin
         reqSeen_q      <= 1'b0;
         busSt_q        <= ST_IDLE;
         sysBusRdData   <= 16'h0000;
         sysBusRdDataOe <= 1'b0;
         mailbox_q      <= 16'h0000;
         hits_q         <= 16'h0000;
         hitEv          <= 1'b0;
      end else begin
         hitEv     <= 1'b0;
         reqSeen_q <= busReq;
         case (busSt_q)
            ST_IDLE: begin
               sysBusRdDataOe <= 1'b0;
               if (busReq && reqSeen_q && windowHit) begin
                  busSt_q <= ST_DONE;
                  hitEv   <= 1'b1;
                  hits_q  <= hits_q + 16'h0001;
                  if (sysBusWrite)
                     mailbox_q <= sysBusWrData;
                  else begin
                     sysBusRdData   <= sysBusOffset[0] ? mailbox_q : axisStatusWord;
                     sysBusRdDataOe <= 1'b1;
                  end
               end
            end
            ST_DONE: begin
               busSt_q <= ST_HOLD;
            end
            ST_HOLD: begin
               if (!busReq) begin
                  busSt_q        <= ST_IDLE;
                  sysBusRdDataOe <= 1'b0;
               end
            end
            default: busSt_q <= ST_IDLE;
         endcase
      end
   end
   // Ready is only ever driven as a target answer, never as a request.
   assign sysBusReady   = (busSt_q != ST_IDLE);
   assign sysBusReadyOe = (busSt_q != ST_IDLE);

   // Interrupt events.
   reg [`EV_WIDTH-1:0] prevEv_q;
   reg [`EV_WIDTH-1:0] irqStat_q;
   reg [`EV_WIDTH-1:0] irqMask_q;
   wire [`EV_WIDTH-1:0] evLevel = {1'b0, targetIndicator, reference_reached_indicator,
                                   limitIndicator, readyIndicator};
   wire [`EV_WIDTH-1:0] evPulse = (evLevel & ~prevEv_q) | {hitEv, 4'h0};
   wire statRead = avs_read && (avs_address == `REG_IRQ_STATUS);
   always @(posedge ref_clk) begin
      if (!cardRst_n) begin
         prevEv_q  <= {`EV_WIDTH{1'b0}};
         irqStat_q <= {`EV_WIDTH{1'b0}};
      end else begin
         prevEv_q  <= evLevel;
         irqStat_q <= (statRead ? {`EV_WIDTH{1'b0}} : irqStat_q) | evPulse;
      end
   end
   assign irq = |(irqStat_q & irqMask_q);

   // Avalon-MM slave, zero wait states.
   assign avs_waitrequest = 1'b0;
   always @(posedge ref_clk) begin
      if (!cardRst_n) begin
         ctrl_q    <= `CTRL_RESET_VALUE;
         irqMask_q <= {`EV_WIDTH{1'b0}};
      end else if (avs_write) begin
         if (avs_address == `REG_CONTROL)
            ctrl_q <= avs_writedata[7:0];
         if (avs_address == `REG_IRQ_MASK)
            irqMask_q <= avs_writedata[`EV_WIDTH-1:0];
      end
   end
   always @* begin
      case (avs_address)
         `REG_CONTROL:       avs_readdata = {24'h000000, ctrl_q};
         `REG_STATUS:        avs_readdata = {25'h0000000, dirNegIndicator, dirPosIndicator,
                                             targetIndicator, reference_reached_indicator,
                                             limitIndicator, readyIndicator, windowHit};
         `REG_IRQ_STATUS:    avs_readdata = {27'h0000000, irqStat_q};
         `REG_IRQ_MASK:      avs_readdata = {27'h0000000, irqMask_q};
         `REG_MODULE_NUMBER: avs_readdata = {24'h000000, swSync_q};
         `REG_WINDOW_BASE:   avs_readdata = {`PASSIVE_SEGMENT, windowBase};
         `REG_HITS:          avs_readdata = {16'h0000, hits_q};
         default:            avs_readdata = 32'h00000000;
      endcase
   end
endmodule
`default_nettype wire

// [verification/axis_unit_asserts.sv]
// Concurrent checks on the bus decode and indicator outputs.
`default_nettype none
module axis_unit_asserts (
   input wire logic        ref_clk, rst_n, frontResetBtn_n,
   input wire logic [7:0]  module_number_switch,
   input wire logic [15:0] sysBusSegment, sysBusOffset,
   input wire logic        sysBusRead, sysBusWrite, sysBusRdDataOe, sysBusReady, sysBusReadyOe,
   input wire logic        axisLimitReached, refPointReached, axisReadyOut, readyIndicator,
   input wire logic        limitIndicator, dirPosIndicator, dirNegIndicator,
   input wire logic        reference_reached_indicator, cardReset,
   input wire logic        avs_write,
   input wire logic [7:0]  avs_address,
   input wire logic [31:0] avs_writedata
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence inWindow;
      sysBusSegment == 16'h2000 && sysBusOffset[15:8] == 8'hFF - module_number_switch;
   endsequence
   sequence readOpen;
      sysBusRead && !sysBusReady;
   endsequence
   window_only_a: assert property (sysBusReadyOe && (sysBusRead || sysBusWrite) |-> inWindow)
      else $error("answer outside window");
   answer_bound_a: assert property (readOpen ##0 inWindow |-> ##[1:4] (sysBusReady || !sysBusRead))
      else $error("no answer in window");
   ready_release_a: assert property ($fell(sysBusRead) && !sysBusWrite |-> ##[0:1] !sysBusReady)
      else $error("ready held after request");
   data_drive_a: assert property (sysBusRdDataOe |-> sysBusRead || $past(sysBusRead))
      else $error("data driven without read");
   ready_mirror_a: assert property (avs_write && avs_address == 8'h00 |-> ##2
      readyIndicator == $past(avs_writedata[0], 2) && axisReadyOut == readyIndicator)
      else $error("ready lamp differs");
   limit_lamp_a: assert property ($rose(axisLimitReached) |-> ##[1:5] limitIndicator)
      else $error("limit lamp late");
   dir_apart_a: assert property (!(dirPosIndicator && dirNegIndicator))
      else $error("both direction lamps lit");
   ref_lamp_a: assert property ($rose(refPointReached) |-> ##[1:5] reference_reached_indicator)
      else $error("reference lamp late");
   local_reset_a: assert property ($fell(frontResetBtn_n) |-> ##[1:8] cardReset)
      else $error("no local reset");
endmodule
bind axis_unit_bus_decode_status axis_unit_asserts chk_i (.ref_clk, .rst_n, .frontResetBtn_n,
   .module_number_switch, .sysBusSegment, .sysBusOffset, .sysBusRead, .sysBusWrite,
   .sysBusRdDataOe, .sysBusReady, .sysBusReadyOe, .axisLimitReached, .refPointReached,
   .axisReadyOut, .readyIndicator, .limitIndicator, .dirPosIndicator, .dirNegIndicator,
   .reference_reached_indicator, .cardReset, .avs_write, .avs_address, .avs_writedata);
`default_nettype wire

// [verification/plc_master_model.sv]
// Active bus controller that issues one backplane transfer per go pulse.
`default_nettype none
module plc_master_model (
   input wire logic         ref_clk, go, wr, rdy,
   input wire logic [15:0]  seg, off, wd, rdIn,
   output var logic [15:0]  busSeg = 16'h0000, busOff = 16'h0000, busWd = 16'h0000,
   output var logic [15:0]  rdv = 16'h0000,
   output var logic         busRd = 1'b0, busWr = 1'b0, done = 1'b0, late = 1'b0
);
   int n = 0;
   always @(posedge ref_clk) begin
      done <= 1'b0;
      late <= 1'b0;
      if (busRd || busWr) begin
         n <= n + 1;
         if (rdy || n == 15) begin
            rdv <= (busRd && rdy) ? rdIn : 16'h0000;
            done <= rdy;
            late <= !rdy;
            busRd <= 1'b0;
            busWr <= 1'b0;
            // Released lines must not keep showing the last address or data.
            busOff <= ~busOff;
            busWd <= ~busWd;
         end
      end else if (go) begin
         busRd <= !wr;
         busWr <= wr;
         busSeg <= seg;
         busOff <= off;
         busWd <= wd;
         n <= 0;
      end
   end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the axis unit decode, indicators and registers.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, btn_n = 1, lim = 0, dPos = 0, dNeg = 0, tgt = 0, refP = 0;
   logic avRd = 0, avWr = 0, go = 0, wr = 0;
   logic [7:0] modNum = 8'h00, avAddr = 8'h00;
   logic [15:0] seg = 16'h0000, off = 16'h0000, wd = 16'h0000, stWord = 16'h0000, base;
   logic [31:0] avWd = 32'h0, rnd = 32'h00005326, got;
   wire [15:0] bSeg, bOff, bWd, rdOut, rdv;
   wire [31:0] avRdData;
   wire bRd, bWr, rdy, rdyOe, rdOe, done, late, aRdy, rInd, lInd, pInd, nInd, tInd, fInd, cRst;
   wire waitReq, irq;
   logic [16:0] expQ[$];
   int failures = 0, total_checks = 0;
   axis_unit_bus_decode_status dut (.ref_clk, .rst_n, .frontResetBtn_n(btn_n),
      .module_number_switch(modNum), .sysBusSegment(bSeg), .sysBusOffset(bOff),
      .sysBusRead(bRd), .sysBusWrite(bWr), .sysBusWrData(bWd), .sysBusRdData(rdOut),
      .sysBusRdDataOe(rdOe), .sysBusReady(rdy), .sysBusReadyOe(rdyOe), .axisLimitReached(lim),
      .driveMovingPos(dPos), .driveMovingNeg(dNeg), .axisInTarget(tgt), .refPointReached(refP),
      .axisStatusWord(stWord), .axisReadyOut(aRdy), .readyIndicator(rInd), .limitIndicator(lInd),
      .dirPosIndicator(pInd), .dirNegIndicator(nInd), .targetIndicator(tInd),
      .reference_reached_indicator(fInd), .cardReset(cRst), .avs_address(avAddr),
      .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWd), .avs_readdata(avRdData),
      .avs_waitrequest(waitReq), .irq);
   plc_master_model plc (.ref_clk, .go, .wr, .rdy(rdyOe & rdy), .seg, .off, .wd,
      .rdIn(rdOe ? rdOut : 16'hFFFF), .busSeg(bSeg), .busOff(bOff), .busWd(bWd), .rdv,
      .busRd(bRd), .busWr(bWr), .done, .late);
   initial forever #2.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic complete_run;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      avRd <= !w; avWr <= w; avAddr <= a; avWd <= d;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (waitReq !== 1'b0 && n < 50);
      got = avRdData;
      if (n >= 50) begin failures++; complete_run(); end
      avRd <= 1'b0; avWr <= 1'b0;
   endtask
   task automatic bp(input logic w, input logic [15:0] o, input logic [15:0] d, input logic [16:0] e);
      int n;
      expQ.push_back(e);
      @(posedge ref_clk);
      go <= 1'b1; wr <= w; seg <= 16'h2000; off <= o; wd <= d;
      @(posedge ref_clk);
      go <= 1'b0;
      n = 0;
      while (!(done || late) && n < 40) begin @(posedge ref_clk); n++; end
      if (n >= 40) begin failures++; complete_run(); end
      @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) if (done || late) begin
      if (expQ.size() == 0) chk(32'h1, 32'h0);
      else chk({late, rdv}, expQ.pop_front());
   end
   initial begin
      rnd = xs(rnd);
      modNum <= rnd[7:0];
      stWord <= rnd[31:16];
      base = {8'hFF - rnd[7:0], 8'h00};
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      av(1, 8'h0C, 32'h1F);
      av(1, 8'h00, 32'h1);
      repeat (4) @(posedge ref_clk);
      chk({aRdy, rInd}, 32'h3);
      av(0, 8'h0C, 0); chk(got, 32'h1F);
      av(0, 8'h10, 0); chk(got, {24'h0, modNum});
      av(0, 8'h14, 0); chk(got, {16'h2000, base});
      av(0, 8'hFC, 0); chk(got, 32'h0);
      rnd = xs(rnd);
      bp(1, base | 16'h0001, rnd[15:0], 17'h0);
      bp(0, base | 16'h00FF, 0, {1'b0, rnd[15:0]});
      bp(0, base, 0, {1'b0, stWord});
      bp(0, base - 16'h0100, 0, 17'h10000);
      bp(0, base + 16'h0100, 0, 17'h10000);
      av(0, 8'h18, 0); chk(got, 32'h3);
      av(0, 8'h08, 0); chk(got, 32'h11);
      for (int i = 0; i < 5; i++) begin
         {refP, tgt, dNeg, dPos, lim} <= 5'h01 << i;
         repeat (6) @(posedge ref_clk);
         chk({fInd, tInd, nInd, pInd, lInd}, 32'h1 << i);
      end
      av(0, 8'h04, 0); chk(got & 32'hFFFFFFFE, 32'h0A);
      chk(irq, 32'h1);
      av(0, 8'h08, 0); chk(got, 32'h0E);
      repeat (2) @(posedge ref_clk);
      chk(irq, 32'h0);
      av(1, 8'h0C, 32'h0);
      lim <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(irq, 32'h0);
      av(0, 8'h08, 0); chk(got, 32'h02);
      btn_n <= 1'b0;
      for (int n = 0; n < 10 && cRst !== 1'b1; n++) @(posedge ref_clk);
      chk(cRst, 32'h1);
      btn_n <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk({aRdy, rInd}, 32'h0);
      av(0, 8'h10, 0); chk(got, {24'h0, modNum});
      complete_run();
   end
endmodule
`default_nettype wire
